// *** rtl/fault_sup_cfg.svh ***
/*
 * Register offsets, field positions, reset values and timing counts of the
 * drive fault supervisor. Assumes a 25 MHz system clock and 32-bit Wishbone.
 */
`ifndef FAULT_SUP_CFG_SVH
`define FAULT_SUP_CFG_SVH

`define FS_CLK_HZ            25000000
`define FS_TICK_US           100
`define FS_TICK_CYCLES       ((`FS_CLK_HZ / 1000000) * `FS_TICK_US)

`define FS_ADDR_REACT        8'h00
`define FS_ADDR_LEVELS       8'h04
`define FS_ADDR_DELAYS       8'h08
`define FS_ADDR_OPEN_TIME    8'h0c
`define FS_ADDR_COMM         8'h10
`define FS_ADDR_CTRL         8'h14
`define FS_ADDR_STATUS       8'h18
`define FS_ADDR_MEASURE      8'h1c

`define FS_OPEN_REACT_POS    0
`define FS_OVSP_REACT_POS    4
`define FS_DEV_REACT_POS     8
`define FS_COMM_REACT_POS    0
`define FS_EXT_DET_POS       4
`define FS_EXT_REACT_POS     8
`define FS_OVERRIDE_POS      12
`define FS_COMM_RST_SEL_POS  16

`define FS_OPEN_REACT_RST    2'h1
`define FS_OVSP_REACT_RST    2'h1
`define FS_DEV_REACT_RST     2'h3
`define FS_COMM_REACT_RST    3'h1
`define FS_EXT_DET_RST       1'h0
`define FS_EXT_REACT_RST     2'h1
`define FS_OVERRIDE_RST      1'h0
`define FS_COMM_RST_SEL_RST  1'h0

`define FS_OVSP_LEVEL_RST    8'h73
`define FS_DEV_LEVEL_RST     8'h0a
`define FS_OVSP_LEVEL_MAX    8'h78
`define FS_DEV_LEVEL_MAX     8'h32
`define FS_OVSP_DELAY_RST    16'h000a
`define FS_DEV_DELAY_RST     16'h0005
`define FS_OPEN_TIME_RST     16'h0014
`define FS_OVSP_DELAY_MAX    16'h0014
`define FS_DEV_DELAY_MAX     16'h0064
`define FS_OPEN_TIME_MAX     16'h0064

`define FS_TENTH_S_TICKS     16'h03e8

`endif

// *** rtl/fault_sup_pkg.sv ***
/*
 * Types of the drive fault supervisor. Assumes fault_sup_cfg.svh for numbers.
 */
package fault_sup_pkg;
  typedef enum logic [2:0] {
    REACT_RAMP       = 3'h0,
    REACT_COAST      = 3'h1,
    REACT_FAST       = 3'h2,
    REACT_ALARM      = 3'h3,
    REACT_ALARM_RUN  = 3'h4,
    REACT_ALARM_RAMP = 3'h5
  } reaction_e;

  typedef enum logic [1:0] {
    STOP_NONE  = 2'h0,
    STOP_RAMP  = 2'h1,
    STOP_COAST = 2'h2,
    STOP_FAST  = 2'h3
  } stop_e;
endpackage : fault_sup_pkg

// *** rtl/drive_fault_supervisor.sv ***
/*
 * Drive fault supervisor: pulse feedback supervision, network fault
 * reactions, multi-step override and communication-settings reset.
 * Assumes a classic Wishbone master on clk and an asynchronous pulse pin.
 */
// Our own choices: register access over Wishbone and the register addresses.
`timescale 1ns/100ps
`include "fault_sup_cfg.svh"

// Operation
// - Pulse input measured as speed feedback
// - Feedback supervision only with motor one
// - Reaction codes ramp, coast, fast, alarm
// - Alarm-only flags fault, motor keeps running
// - Three feedback reactions, defaults one, one, three
// - Overspeed above level longer than delay
// - Deviation beyond level longer than delay
// - Open circuit when pulses absent too long
// - Communication error reaction codes zero to five
// - External fault always or only running
// - External fault reaction codes zero to three
// - Selection zero ignores multi-step on network
// - Selection one lets multi-step override network
// - Initialization resets comm settings if selected
// - Reset selection survives initialization
module drive_fault_supervisor #(
  parameter int TICK_CYCLES = `FS_TICK_CYCLES,
  parameter int SPEED_W     = 16
) (
  input  wire logic               clk,
  input  wire logic               rst_b,
  input  wire logic               clk_en,
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [7:0]         wb_adr_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire logic [31:0]        wb_dat_i,
  output logic      [31:0]        wb_dat_o,
  output logic                    wb_ack_o,
  input  wire logic               pulse_train_input,
  input  wire logic               motor_two_select,
  input  wire logic               running,
  input  wire logic [SPEED_W-1:0] max_freq_pulses,
  input  wire logic [SPEED_W-1:0] freq_reference,
  input  wire logic               comm_error,
  input  wire logic               network_external_fault,
  input  wire logic               network_reference_select,
  input  wire logic               multistep_active,
  input  wire logic               initialize_command,
  output logic                    feedback_open_fault,
  output logic                    overspeed_fault,
  output logic                    speed_deviation_fault,
  output logic                    comm_error_fault,
  output logic                    ext_fault,
  output logic [1:0]              stop_mode,
  output logic                    preset_run,
  output logic                    multistep_select,
  output logic [SPEED_W-1:0]      speed_feedback
);
  logic [1:0]  open_fault_reaction;
  logic [1:0]  overspeed_reaction;
  logic [1:0]  deviation_reaction;
  logic [2:0]  comm_error_reaction;
  logic        ext_fault_detect_select;
  logic [1:0]  ext_fault_reaction;
  logic        multistep_override_select;
  logic        comm_settings_reset_select;
  logic [7:0]  overspeed_level;
  logic [7:0]  deviation_level;
  logic [15:0] overspeed_delay;
  logic [15:0] deviation_delay;
  logic [15:0] open_detect_time;
  logic [2:0]  pulse_sync;
  logic        pulse_level;
  logic        pulse_edge;
  logic [31:0] tick_count;
  logic        tick;
  logic [9:0]  sub_tenth;
  logic        tenth;
  logic [SPEED_W-1:0] pulse_count;
  logic [15:0] open_timer;
  logic [15:0] ovsp_timer;
  logic [15:0] dev_timer;
  logic        feedback_on;
  logic        ovsp_cond;
  logic        dev_cond;
  logic [SPEED_W-1:0] speed_diff;
  logic        bus_req;
  logic        bus_wr;
  logic [31:0] next_rdata;

  // Scales a percentage of maximum frequency to pulses per measuring window
  function automatic logic [SPEED_W-1:0] pct_of_max(input logic [7:0] pct,
                                                    input logic [SPEED_W-1:0] mx);
    logic [SPEED_W+7:0] prod;
    prod = SPEED_W'(mx) * (SPEED_W+8)'(pct);
    return SPEED_W'(prod / (SPEED_W+8)'(100));
  endfunction : pct_of_max

  // Maps a reaction code onto the stop request it produces
  function automatic logic [1:0] stop_of(input logic [2:0] code);
    case (code)
      3'h0, 3'h5: return fault_sup_pkg::STOP_RAMP;
      3'h1:       return fault_sup_pkg::STOP_COAST;
      3'h2:       return fault_sup_pkg::STOP_FAST;
      default:    return fault_sup_pkg::STOP_NONE;
    endcase
  endfunction : stop_of

  // Clamps a written field to its documented top value
  function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] mx);
    return (v > mx) ? mx : v;
  endfunction : clamp16

  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign bus_wr  = bus_req && wb_we_i && clk_en;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else if (clk_en) begin
      wb_ack_o <= bus_req;
      if (bus_req && !wb_we_i) begin
        wb_dat_o <= next_rdata;
      end
    end
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    unique case (wb_adr_i)
      `FS_ADDR_REACT: begin
        next_rdata[`FS_OPEN_REACT_POS +: 2] = open_fault_reaction;
        next_rdata[`FS_OVSP_REACT_POS +: 2] = overspeed_reaction;
        next_rdata[`FS_DEV_REACT_POS +: 2]  = deviation_reaction;
      end
      `FS_ADDR_LEVELS:    next_rdata = {8'h00, deviation_level, 8'h00, overspeed_level};
      `FS_ADDR_DELAYS:    next_rdata = {deviation_delay, overspeed_delay};
      `FS_ADDR_OPEN_TIME: next_rdata = {16'h0000, open_detect_time};
      `FS_ADDR_COMM: begin
        next_rdata[`FS_COMM_REACT_POS +: 3] = comm_error_reaction;
        next_rdata[`FS_EXT_DET_POS]         = ext_fault_detect_select;
        next_rdata[`FS_EXT_REACT_POS +: 2]  = ext_fault_reaction;
        next_rdata[`FS_OVERRIDE_POS]        = multistep_override_select;
        next_rdata[`FS_COMM_RST_SEL_POS]    = comm_settings_reset_select;
      end
      `FS_ADDR_STATUS: next_rdata = {24'h0, stop_mode, preset_run, ext_fault,
                                     comm_error_fault, speed_deviation_fault,
                                     overspeed_fault, feedback_open_fault};
      `FS_ADDR_MEASURE: next_rdata = 32'(speed_feedback);
      default:          next_rdata = 32'h0000_0000;
    endcase
  end

  // Feedback settings; a write with byte lane 0 set updates the low field
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      open_fault_reaction <= `FS_OPEN_REACT_RST;
      overspeed_reaction  <= `FS_OVSP_REACT_RST;
      deviation_reaction  <= `FS_DEV_REACT_RST;
      overspeed_level     <= `FS_OVSP_LEVEL_RST;
      deviation_level     <= `FS_DEV_LEVEL_RST;
      overspeed_delay     <= `FS_OVSP_DELAY_RST;
      deviation_delay     <= `FS_DEV_DELAY_RST;
      open_detect_time    <= `FS_OPEN_TIME_RST;
    end else if (bus_wr) begin
      if (wb_adr_i == `FS_ADDR_REACT && wb_sel_i[0]) begin
        open_fault_reaction <= wb_dat_i[`FS_OPEN_REACT_POS +: 2];
        overspeed_reaction  <= wb_dat_i[`FS_OVSP_REACT_POS +: 2];
      end
      if (wb_adr_i == `FS_ADDR_REACT && wb_sel_i[1]) begin
        deviation_reaction <= wb_dat_i[`FS_DEV_REACT_POS +: 2];
      end
      if (wb_adr_i == `FS_ADDR_LEVELS && wb_sel_i[0]) begin
        overspeed_level <= 8'(clamp16({8'h00, wb_dat_i[7:0]}, {8'h00, `FS_OVSP_LEVEL_MAX}));
      end
      if (wb_adr_i == `FS_ADDR_LEVELS && wb_sel_i[2]) begin
        deviation_level <= 8'(clamp16({8'h00, wb_dat_i[23:16]}, {8'h00, `FS_DEV_LEVEL_MAX}));
      end
      if (wb_adr_i == `FS_ADDR_DELAYS && wb_sel_i[0]) begin
        overspeed_delay <= clamp16(wb_dat_i[15:0], `FS_OVSP_DELAY_MAX);
      end
      if (wb_adr_i == `FS_ADDR_DELAYS && wb_sel_i[2]) begin
        deviation_delay <= clamp16(wb_dat_i[31:16], `FS_DEV_DELAY_MAX);
      end
      if (wb_adr_i == `FS_ADDR_OPEN_TIME && wb_sel_i[0]) begin
        open_detect_time <= clamp16(wb_dat_i[15:0], `FS_OPEN_TIME_MAX);
      end
    end
  end

  // Communication settings; initialization beats a same-cycle bus write
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      comm_error_reaction        <= `FS_COMM_REACT_RST;
      ext_fault_detect_select    <= `FS_EXT_DET_RST;
      ext_fault_reaction         <= `FS_EXT_REACT_RST;
      multistep_override_select  <= `FS_OVERRIDE_RST;
      comm_settings_reset_select <= `FS_COMM_RST_SEL_RST;
    end else if (clk_en) begin
      if (initialize_command && comm_settings_reset_select) begin
        comm_error_reaction       <= `FS_COMM_REACT_RST;
        ext_fault_detect_select   <= `FS_EXT_DET_RST;
        ext_fault_reaction        <= `FS_EXT_REACT_RST;
        multistep_override_select <= `FS_OVERRIDE_RST;
      end else if (bus_wr && wb_adr_i == `FS_ADDR_COMM) begin
        if (wb_sel_i[0]) begin
          comm_error_reaction     <= (wb_dat_i[2:0] > 3'h5) ? 3'h5 : wb_dat_i[2:0];
          ext_fault_detect_select <= wb_dat_i[`FS_EXT_DET_POS];
        end
        if (wb_sel_i[1]) begin
          ext_fault_reaction        <= wb_dat_i[`FS_EXT_REACT_POS +: 2];
          multistep_override_select <= wb_dat_i[`FS_OVERRIDE_POS];
        end
      end
      if (bus_wr && wb_adr_i == `FS_ADDR_COMM && wb_sel_i[2]) begin
        comm_settings_reset_select <= wb_dat_i[`FS_COMM_RST_SEL_POS];
      end
    end
  end

  // Three-stage pin synchroniser; only stages two and three are compared
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pulse_sync  <= 3'h0;
      pulse_level <= 1'b0;
    end else if (clk_en) begin
      pulse_sync <= {pulse_sync[1:0], pulse_train_input};
      if (pulse_sync[1] == pulse_sync[2]) begin
        pulse_level <= pulse_sync[2];
      end
    end
  end
  assign pulse_edge = (pulse_sync[1] == pulse_sync[2]) && pulse_sync[2] && !pulse_level;

  // 100 us tick, 0.1 s sub-tick; speed is pulses counted per 0.1 s window
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      tick_count     <= 32'h0;
      sub_tenth      <= 10'h000;
      pulse_count    <= '0;
      speed_feedback <= '0;
    end else if (clk_en) begin
      tick_count <= tick ? 32'h0 : tick_count + 32'h1;
      if (tenth) begin
        sub_tenth      <= 10'h000;
        speed_feedback <= pulse_count;
        pulse_count    <= pulse_edge ? SPEED_W'(1) : '0;
      end else begin
        if (tick) begin
          sub_tenth <= sub_tenth + 10'h001;
        end
        if (pulse_edge) begin
          pulse_count <= pulse_count + SPEED_W'(1);
        end
      end
    end
  end
  assign tick  = (tick_count == 32'(TICK_CYCLES - 1));
  assign tenth = tick && (sub_tenth == 10'(`FS_TENTH_S_TICKS - 16'h0001));

  assign feedback_on = !motor_two_select;
  assign speed_diff  = (speed_feedback > freq_reference) ? speed_feedback - freq_reference
                                                         : freq_reference - speed_feedback;
  assign ovsp_cond = feedback_on
                  && speed_feedback > pct_of_max(overspeed_level, max_freq_pulses);
  assign dev_cond  = feedback_on
                  && speed_diff > pct_of_max(deviation_level, max_freq_pulses);

  // Timers count 0.1 s steps; a fault needs strictly more steps than set
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      open_timer            <= 16'h0;
      ovsp_timer            <= 16'h0;
      dev_timer             <= 16'h0;
      feedback_open_fault   <= 1'b0;
      overspeed_fault       <= 1'b0;
      speed_deviation_fault <= 1'b0;
      comm_error_fault      <= 1'b0;
      ext_fault             <= 1'b0;
    end else if (clk_en) begin
      if (!feedback_on || pulse_edge) begin
        open_timer <= 16'h0;
      end else if (tenth && open_timer <= open_detect_time) begin
        open_timer <= open_timer + 16'h1;
      end
      if (!ovsp_cond) begin
        ovsp_timer <= 16'h0;
      end else if (tenth && ovsp_timer <= overspeed_delay) begin
        ovsp_timer <= ovsp_timer + 16'h1;
      end
      if (!dev_cond) begin
        dev_timer <= 16'h0;
      end else if (tenth && dev_timer <= deviation_delay) begin
        dev_timer <= dev_timer + 16'h1;
      end
      // Sticky until reset, since no clear path is defined for these faults
      if (feedback_on && open_timer > open_detect_time) begin
        feedback_open_fault <= 1'b1;
      end
      if (ovsp_cond && ovsp_timer > overspeed_delay) begin
        overspeed_fault <= 1'b1;
      end
      if (dev_cond && dev_timer > deviation_delay) begin
        speed_deviation_fault <= 1'b1;
      end
      if (comm_error) begin
        comm_error_fault <= 1'b1;
      end
      if (network_external_fault && (!ext_fault_detect_select || running)) begin
        ext_fault <= 1'b1;
      end
    end
  end

  // Stop priority: coast over fast over ramp; alarm codes 3 and 4 never stop, code 5 ramps
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      stop_mode  <= fault_sup_pkg::STOP_NONE;
      preset_run <= 1'b0;
    end else if (clk_en) begin
      logic [1:0] s0, s1, s2, s3, s4;
      s0 = feedback_open_fault   ? stop_of({1'b0, open_fault_reaction}) : 2'h0;
      s1 = overspeed_fault       ? stop_of({1'b0, overspeed_reaction})  : 2'h0;
      s2 = speed_deviation_fault ? stop_of({1'b0, deviation_reaction})  : 2'h0;
      s3 = comm_error_fault      ? stop_of(comm_error_reaction)         : 2'h0;
      s4 = ext_fault             ? stop_of({1'b0, ext_fault_reaction})  : 2'h0;
      if ({s0, s1, s2, s3, s4} == 10'h0) begin
        stop_mode <= fault_sup_pkg::STOP_NONE;
      end else if (s0 == 2'h2 || s1 == 2'h2 || s2 == 2'h2 || s3 == 2'h2 || s4 == 2'h2) begin
        stop_mode <= fault_sup_pkg::STOP_COAST;
      end else if (s0 == 2'h3 || s1 == 2'h3 || s2 == 2'h3 || s3 == 2'h3 || s4 == 2'h3) begin
        stop_mode <= fault_sup_pkg::STOP_FAST;
      end else begin
        stop_mode <= fault_sup_pkg::STOP_RAMP;
      end
      preset_run <= comm_error_fault
                 && comm_error_reaction == fault_sup_pkg::REACT_ALARM_RUN;
    end
  end

  // Multi-step inputs choose the reference unless the network one blocks them
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      multistep_select <= 1'b0;
    end else if (clk_en) begin
      if (network_reference_select && !multistep_override_select) begin
        multistep_select <= 1'b0;
      end else begin
        multistep_select <= multistep_active;
      end
    end
  end
endmodule : drive_fault_supervisor

// *** tb/drive_fault_supervisor_props.sv ***
/* Port checker of the drive fault supervisor.
   Bound by name onto the design top; sees only its ports. */
`timescale 1ns/100ps
module drive_fault_supervisor_props (
  input wire logic       clk,
  input wire logic       rst_b,
  input wire logic       clk_en,
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_ack_o,
  input wire logic       motor_two_select,
  input wire logic       comm_error,
  input wire logic       network_reference_select,
  input wire logic       multistep_active,
  input wire logic       feedback_open_fault,
  input wire logic       overspeed_fault,
  input wire logic       speed_deviation_fault,
  input wire logic       comm_error_fault,
  input wire logic       ext_fault,
  input wire logic [1:0] stop_mode,
  input wire logic       preset_run,
  input wire logic       multistep_select
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic [4:0] flags;
  assign flags = {feedback_open_fault, overspeed_fault, speed_deviation_fault,
                  comm_error_fault, ext_fault};

  AST_ACK_NEXT: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o && clk_en |=> wb_ack_o)
    else $error("request not answered next cycle");
  AST_ACK_ONCE: assert property (
    wb_ack_o && clk_en |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_RESET_CLEAR: assert property (
    disable iff (1'b0) !rst_b |=> flags == 5'h0 && stop_mode == 2'h0)
    else $error("outputs not cleared by reset");
  AST_FLAGS_STICK: assert property (
    flags != 5'h0 |=> (flags & $past(flags)) == $past(flags))
    else $error("fault flag dropped without reset");
  AST_COMM_LATCH: assert property (
    comm_error && clk_en |-> ##[1:3] comm_error_fault)
    else $error("comm error not flagged");
  // The flag is set at the edge that saw motor one selected and is seen high one edge later
  AST_MOTOR_TWO: assert property (
    $rose(feedback_open_fault || overspeed_fault || speed_deviation_fault)
    |-> !$past(motor_two_select))
    else $error("feedback fault with motor two");
  AST_PRESET: assert property (
    preset_run |-> comm_error_fault && stop_mode == 2'h0)
    else $error("preset run without comm fault");
  AST_STOP_CAUSE: assert property (
    stop_mode != 2'h0 |-> flags != 5'h0)
    else $error("stop without fault");
  AST_MULTI_LOCAL: assert property (
    !network_reference_select && multistep_active && clk_en |=> multistep_select)
    else $error("multi-step lost on local reference");
  AST_MULTI_CAUSE: assert property (
    multistep_select |-> $past(multistep_active))
    else $error("multi-step without input");

  COV_COMM: cover property ($rose(comm_error_fault));
  COV_OVSP: cover property ($rose(overspeed_fault));
  COV_PRESET: cover property ($rose(preset_run));
endmodule : drive_fault_supervisor_props

// *** tb/pulse_encoder_model.sv ***
/* Single-track pulse encoder model for the feedback pin.
   Runs on the system clock; the pin rests low while stopped. */
`timescale 1ns/100ps
module pulse_encoder_model (
  input  wire logic        clk,
  input  wire logic        enable,
  input  wire logic [15:0] period,
  output logic             pulse_train_input
);
  logic [15:0] count;
  always_ff @(posedge clk) begin
    if (!enable || count >= period - 16'h1) begin
      count <= 16'h0;
    end else begin
      count <= count + 16'h1;
    end
  end
  // A stopped shaft gives no edges at all, which the open test relies on
  always_ff @(posedge clk) begin
    pulse_train_input <= enable && (count < (period >> 1));
  end
endmodule : pulse_encoder_model

// *** tb/drive_fault_supervisor_tb.sv ***
/* Self-checking bench of the drive fault supervisor.
   Drives Wishbone, network levels and a pulse encoder model. */
`timescale 1ns/100ps
module drive_fault_supervisor_tb;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        clk_en = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h0;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        pulse_train_input;
  logic        motor_two_select = 1'b0;
  logic        running = 1'b0;
  logic [15:0] max_freq_pulses = 16'h64;
  logic [15:0] freq_reference = 16'h0;
  logic        comm_error = 1'b0;
  logic        network_external_fault = 1'b0;
  logic        network_reference_select = 1'b0;
  logic        multistep_active = 1'b0;
  logic        initialize_command = 1'b0;
  logic        feedback_open_fault, overspeed_fault, speed_deviation_fault;
  logic        comm_error_fault, ext_fault, preset_run, multistep_select;
  logic [1:0]  stop_mode;
  logic [15:0] speed_feedback;
  logic        pen = 1'b0;
  logic [15:0] pper = 16'ha;
  logic [2:0]  fb_flags;
  logic [31:0] rd;
  int          errors = 0;
  int          cmp_count = 0;
  int          cycles = 0;
  int          n;

  assign fb_flags = {feedback_open_fault, overspeed_fault, speed_deviation_fault};
  // Small tick so a tenth of a second is 2000 cycles
  drive_fault_supervisor #(.TICK_CYCLES(2), .SPEED_W(16)) i_drive_fault_supervisor (.*);
  pulse_encoder_model i_pulse_encoder_model (.clk(clk), .enable(pen), .period(pper),
                                             .pulse_train_input(pulse_train_input));

  always #20 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 80000) begin
      errors++;
      results();
    end
  end

  task automatic results;
    $display("errors=%0d comparisons=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : results

  task automatic chk(input logic ok, input string msg);
    cmp_count++;
    if (ok !== 1'b1) begin
      errors++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask : chk

  // Waits on ack with no cycle count assumed; the timeout ends a hang
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_sel_i <= 4'hf;
    wb_dat_i <= d;
    do @(posedge clk); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb

  task automatic do_reset;
    @(posedge clk);
    rst_b <= 1'b0;
    comm_error <= 1'b0;
    network_external_fault <= 1'b0;
    running <= 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
  endtask : do_reset

  task automatic t_regs;
    logic [7:0]  a [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h18, 8'h20};
    logic [31:0] e [7] = '{32'h311, 32'ha0073, 32'h5000a, 32'h14, 32'h101, 32'h0, 32'h0};
    do_reset();
    for (int i = 0; i < 7; i++) begin
      wb(1'b0, a[i], 32'h0);
      chk(rd === e[i], "register reset value");
    end
    wb(1'b1, 8'h04, 32'h00ff00ff);
    wb(1'b0, 8'h04, 32'h0);
    chk(rd === 32'h00320078, "level clamp");
  endtask : t_regs

  task automatic t_comm;
    logic [1:0] es [6] = '{2'h1, 2'h2, 2'h3, 2'h0, 2'h0, 2'h1};
    for (int c = 0; c < 6; c++) begin
      do_reset();
      wb(1'b1, 8'h10, 32'h100 | c);
      comm_error <= 1'b1;
      repeat (4) @(posedge clk);
      chk(comm_error_fault === 1'b1 && stop_mode === es[c], "comm reaction");
      chk(preset_run === (c == 4), "preset run");
      wb(1'b0, 8'h18, 32'h0);
      chk(rd === {es[c], (c == 4), 5'h08}, "status word");
    end
  endtask : t_comm

  task automatic t_ext;
    do_reset();
    network_external_fault <= 1'b1;
    repeat (4) @(posedge clk);
    chk(ext_fault === 1'b1 && stop_mode === 2'h2, "ext default coast");
    do_reset();
    wb(1'b1, 8'h10, 32'h311);
    network_external_fault <= 1'b1;
    repeat (4) @(posedge clk);
    chk(ext_fault === 1'b0, "ext fault while stopped");
    running <= 1'b1;
    repeat (4) @(posedge clk);
    chk(ext_fault === 1'b1 && stop_mode === 2'h0, "ext alarm only");
  endtask : t_ext

  task automatic t_override;
    do_reset();
    network_reference_select <= 1'b1;
    multistep_active <= 1'b1;
    repeat (3) @(posedge clk);
    chk(multistep_select === 1'b0, "multi-step ignored");
    wb(1'b1, 8'h10, 32'h1101);
    repeat (3) @(posedge clk);
    chk(multistep_select === 1'b1, "multi-step override");
    network_reference_select <= 1'b0;
    multistep_active <= 1'b0;
  endtask : t_override

  // Clock enable low must hold every latch, a pending comm error included
  task automatic t_freeze;
    do_reset();
    clk_en <= 1'b0;
    comm_error <= 1'b1;
    repeat (4) @(posedge clk);
    chk(comm_error_fault === 1'b0, "state moved with enable low");
    clk_en <= 1'b1;
    repeat (2) @(posedge clk);
    chk(comm_error_fault === 1'b1, "comm error lost after enable");
    comm_error <= 1'b0;
  endtask : t_freeze

  task automatic t_init(input logic [31:0] w, input logic [31:0] e);
    wb(1'b1, 8'h10, w);
    @(posedge clk);
    initialize_command <= 1'b1;
    @(posedge clk);
    initialize_command <= 1'b0;
    wb(1'b0, 8'h10, 32'h0);
    chk(rd === e, "comm settings after init");
  endtask : t_init

  task automatic fb_case(input logic [15:0] per, maxf, rv, input logic [31:0] react, dly,
                         input logic m2, input logic [2:0] ef, input logic [1:0] es);
    do_reset();
    max_freq_pulses <= maxf;
    freq_reference <= rv;
    motor_two_select <= m2;
    wb(1'b1, 8'h00, react);
    wb(1'b1, 8'h08, dly);
    wb(1'b1, 8'h0c, 32'h1);
    pper <= per;
    pen <= (per != 16'h0);
    n = 0;
    while (fb_flags === 3'h0 && n < 10000) begin
      @(posedge clk);
      n++;
    end
    repeat (2) @(posedge clk);
    chk(fb_flags === ef, "feedback fault flags");
    chk(stop_mode === es, "feedback stop mode");
    if (per == 16'ha && !m2) begin
      chk(speed_feedback >= 16'hc7 && speed_feedback <= 16'hc9, "speed count");
      wb(1'b0, 8'h1c, 32'h0);
      chk(rd >= 32'hc7 && rd <= 32'hc9, "speed register");
    end
    pen <= 1'b0;
    motor_two_select <= 1'b0;
  endtask : fb_case

  initial begin
    t_regs();
    t_comm();
    t_ext();
    t_override();
    t_freeze();
    do_reset();
    t_init(32'h11313, 32'h10101);
    t_init(32'h01313, 32'h01313);
    fb_case(16'ha, 16'h64, 16'hc8, 32'h331, 32'h50000, 1'b0, 3'b010, 2'h0);
    fb_case(16'ha, 16'h64, 16'hc8, 32'h331, 32'h50000, 1'b1, 3'b000, 2'h0);
    fb_case(16'ha, 16'h3e8, 16'h0, 32'h031, 32'ha, 1'b0, 3'b001, 2'h1);
    fb_case(16'h0, 16'h64, 16'h0, 32'h312, 32'h5000a, 1'b0, 3'b100, 2'h3);
    results();
  end
endmodule : drive_fault_supervisor_tb

bind drive_fault_supervisor drive_fault_supervisor_props i_drive_fault_supervisor_props (.*);
